/* File: rtl/dpmd_bank.sv */
// One dual-ported SRAM block stored as 16-bit lanes
`timescale 1ns/1ps
module dpmd_bank (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [1:0] i_en,
   input wire logic [1:0] i_write,
   input wire logic [1:0][dpmd_pkg::SRAM_IDX_W-1:0] i_index,
   input wire logic [1:0][2:0] i_lanes,
   input wire logic [1:0][dpmd_pkg::DATA_W-1:0] i_wdata,
   output logic [1:0][dpmd_pkg::DATA_W-1:0] o_rdata
);

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   // One short-word array serves every view, so widths share the block's half megabit
   logic [dpmd_pkg::LANE_W-1:0] mem_reg [0:dpmd_pkg::SRAM_SHORTS-1];
   logic [dpmd_pkg::DATA_W-1:0] rdata_reg [2];

   // Port 0 written last so the core wins a same-cycle collision
   always_ff @(posedge i_clock) begin
      for (int p = 1; p >= 0; p--) begin
         for (int l = 0; l < dpmd_pkg::LANES; l++) begin
            if (i_en[p] && i_write[p] && (3'(l) < i_lanes[p])) begin
               mem_reg[15'(i_index[p] + 15'(l))] <= i_wdata[p][dpmd_pkg::LANE_W*l +: dpmd_pkg::LANE_W];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Independent read ports
   // ------------------------------------------------------------------
   for (genvar p = 0; p < 2; p++) begin : g_port
      always_ff @(posedge i_clock) begin
         if (i_sys_rst) begin
            rdata_reg[p] <= '0;
         end else if (i_en[p]) begin
            for (int l = 0; l < dpmd_pkg::LANES; l++) begin
               rdata_reg[p][dpmd_pkg::LANE_W*l +: dpmd_pkg::LANE_W] <=
                  (3'(l) < i_lanes[p]) ? mem_reg[15'(i_index[p] + 15'(l))] : 16'h0000;
            end
         end
      end
      assign o_rdata[p] = rdata_reg[p];
   end

endmodule

/* File: rtl/dpmd_decoder.sv */
// Address decoder and three-bus front end for the internal SRAM and ROM blocks
`timescale 1ns/1ps
module dpmd_decoder (
   input wire logic I_CLOCK,
   input wire logic I_SYS_RST,
   input wire dpmd_pkg::dpmd_req_type I_DATA_MEMORY_BUS_REQ,
   input wire dpmd_pkg::dpmd_req_type I_PROGRAM_MEMORY_BUS_REQ,
   input wire dpmd_pkg::dpmd_req_type I_IO_PROCESSOR_REQ,
   output logic O_PROGRAM_MEMORY_BUS_STALL,
   output dpmd_pkg::dpmd_rsp_type O_DATA_MEMORY_BUS_RSP,
   output dpmd_pkg::dpmd_rsp_type O_PROGRAM_MEMORY_BUS_RSP,
   output dpmd_pkg::dpmd_rsp_type O_IO_PROCESSOR_RSP
);

   // ------------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------------
   function automatic dpmd_pkg::dpmd_dec_type decode(input dpmd_pkg::dpmd_req_type r);
      dpmd_pkg::dpmd_dec_type d;
      logic [31:0] off;
      logic [31:0] sidx;
      logic [31:0] size;
      logic [2:0] n;
      d = '{region: dpmd_pkg::REGION_RESERVED, blk: 1'b0, idx: '0, lanes: 3'h0};
      if (r.addr <= dpmd_pkg::IOREG_LAST) begin
         d.region = dpmd_pkg::REGION_IOREG;
      end else begin
         for (int k = 0; k < dpmd_pkg::MAP_ENTRIES; k++) begin
            if (r.addr >= dpmd_pkg::MAP[k].lo && r.addr <= dpmd_pkg::MAP[k].hi) begin
               off = r.addr - dpmd_pkg::MAP[k].lo;
               // Every view scales onto the same short-word index
               unique case (dpmd_pkg::MAP[k].view)
                  dpmd_pkg::VIEW_LONG: begin
                     n = 3'h4;
                     sidx = 32'(off * 32'h0000_0004);
                  end
                  dpmd_pkg::VIEW_NORMAL: begin
                     n = r.wide48 ? 3'h3 : 3'h2;
                     sidx = r.wide48 ? 32'(off * 32'h0000_0003) : 32'(off * 32'h0000_0002);
                  end
                  dpmd_pkg::VIEW_SHORT: begin
                     n = 3'h1;
                     sidx = off;
                  end
                  default: begin
                     n = 3'h0;
                     sidx = 32'h0000_0000;
                  end
               endcase
               size = (dpmd_pkg::MAP[k].region == dpmd_pkg::REGION_SRAM) ?
                      dpmd_pkg::SRAM_SHORTS : dpmd_pkg::ROM_SHORTS;
               // A 48-bit word running past the block end stays unmapped
               if (n != 3'h0 && (sidx + 32'(n)) <= size) begin
                  d.region = dpmd_pkg::MAP[k].region;
                  d.blk = dpmd_pkg::MAP[k].blk;
                  d.idx = sidx[dpmd_pkg::ROM_IDX_W-1:0];
                  d.lanes = n;
               end
            end
         end
      end
      return d;
   endfunction

   function automatic logic [dpmd_pkg::DATA_W-1:0] rom_read(input dpmd_pkg::dpmd_dec_type d);
      logic [dpmd_pkg::DATA_W-1:0] v;
      logic [dpmd_pkg::ROM_IDX_W-1:0] a;
      v = '0;
      for (int l = 0; l < dpmd_pkg::LANES; l++) begin
         a = 17'(d.idx + 17'(l));
         if (3'(l) < d.lanes) begin
            v[dpmd_pkg::LANE_W*l +: dpmd_pkg::LANE_W] = {d.blk, a[14:0]} ^ dpmd_pkg::ROM_PATTERN;
         end
      end
      return v;
   endfunction

   // ------------------------------------------------------------------
   // Per-bus decode; bus 0 data, 1 program, 2 io_processor
   // ------------------------------------------------------------------
   dpmd_pkg::dpmd_req_type req [dpmd_pkg::NUM_BUSES];
   dpmd_pkg::dpmd_dec_type dec [dpmd_pkg::NUM_BUSES];
   dpmd_pkg::dpmd_rsp_type rsp [dpmd_pkg::NUM_BUSES];
   logic [dpmd_pkg::NUM_BUSES-1:0] accept;
   logic [dpmd_pkg::NUM_BLOCKS-1:0] dmb_hit;
   logic [dpmd_pkg::NUM_BLOCKS-1:0] pmb_hit;
   logic [dpmd_pkg::NUM_BLOCKS-1:0] iob_hit;
   logic [dpmd_pkg::NUM_BLOCKS-1:0][1:0][dpmd_pkg::DATA_W-1:0] bank_rdata;

   assign req[0] = I_DATA_MEMORY_BUS_REQ;
   assign req[1] = I_PROGRAM_MEMORY_BUS_REQ;
   assign req[2] = I_IO_PROCESSOR_REQ;

   for (genvar k = 0; k < dpmd_pkg::NUM_BUSES; k++) begin : g_dec
      assign dec[k] = decode(req[k]);
   end

   // ------------------------------------------------------------------
   // Block port steering
   // ------------------------------------------------------------------
   for (genvar b = 0; b < dpmd_pkg::NUM_BLOCKS; b++) begin : g_blk
      logic [1:0] en;
      logic [1:0] wr;
      logic [1:0][dpmd_pkg::SRAM_IDX_W-1:0] index;
      logic [1:0][2:0] lanes;
      logic [1:0][dpmd_pkg::DATA_W-1:0] wdata;
      logic use_pmb;

      assign dmb_hit[b] = req[0].valid && dec[0].region == dpmd_pkg::REGION_SRAM && dec[0].blk == 1'(b);
      assign pmb_hit[b] = req[1].valid && dec[1].region == dpmd_pkg::REGION_SRAM && dec[1].blk == 1'(b);
      assign iob_hit[b] = req[2].valid && dec[2].region == dpmd_pkg::REGION_SRAM && dec[2].blk == 1'(b);
      // Core port goes to the data bus first; program bus only if it is alone
      assign use_pmb = pmb_hit[b] && !dmb_hit[b];

      assign en[0] = dmb_hit[b] || pmb_hit[b];
      assign wr[0] = use_pmb ? req[1].write : req[0].write;
      assign index[0] = use_pmb ? dec[1].idx[14:0] : dec[0].idx[14:0];
      assign lanes[0] = use_pmb ? dec[1].lanes : dec[0].lanes;
      assign wdata[0] = use_pmb ? req[1].wdata : req[0].wdata;
      // Second port belongs to the io_processor alone, never contended
      assign en[1] = iob_hit[b];
      assign wr[1] = req[2].write;
      assign index[1] = dec[2].idx[14:0];
      assign lanes[1] = dec[2].lanes;
      assign wdata[1] = req[2].wdata;

      dpmd_bank u_bank (
         .i_clock(I_CLOCK),
         .i_sys_rst(I_SYS_RST),
         .i_en(en),
         .i_write(wr),
         .i_index(index),
         .i_lanes(lanes),
         .i_wdata(wdata),
         .o_rdata(bank_rdata[b])
      );
   end

   // Stall only when both core buses want one SRAM block in one cycle
   assign O_PROGRAM_MEMORY_BUS_STALL = |(dmb_hit & pmb_hit);
   assign accept[0] = req[0].valid;
   assign accept[1] = req[1].valid && !O_PROGRAM_MEMORY_BUS_STALL;
   assign accept[2] = req[2].valid;

   // ------------------------------------------------------------------
   // Responses, one cycle after the request
   // ------------------------------------------------------------------
   for (genvar k = 0; k < dpmd_pkg::NUM_BUSES; k++) begin : g_rsp
      localparam int PORT = (k == 2) ? 1 : 0;
      logic valid_reg;
      dpmd_pkg::dpmd_region_type region_reg;
      logic blk_reg;
      logic [dpmd_pkg::DATA_W-1:0] rom_reg;
      logic [dpmd_pkg::DATA_W-1:0] sram_data;

      // All three buses are served in the same cycle unless the program bus is stalled
      always_ff @(posedge I_CLOCK) begin
         if (I_SYS_RST) begin
            valid_reg <= 1'b0;
            region_reg <= dpmd_pkg::REGION_RESERVED;
            blk_reg <= 1'b0;
            rom_reg <= '0;
         end else begin
            valid_reg <= accept[k];
            region_reg <= dec[k].region;
            blk_reg <= dec[k].blk;
            rom_reg <= (dec[k].region == dpmd_pkg::REGION_ROM) ? rom_read(dec[k]) : '0;
         end
      end

      assign sram_data = bank_rdata[blk_reg][PORT];
      assign rsp[k].valid = valid_reg;
      assign rsp[k].region = region_reg;
      // Reserved and register-region reads give zero here
      assign rsp[k].rdata = (region_reg == dpmd_pkg::REGION_SRAM) ? sram_data :
                            (region_reg == dpmd_pkg::REGION_ROM) ? rom_reg : '0;
   end

   assign O_DATA_MEMORY_BUS_RSP = rsp[0];
   assign O_PROGRAM_MEMORY_BUS_RSP = rsp[1];
   assign O_IO_PROCESSOR_RSP = rsp[2];

endmodule

/* File: rtl/dpmd_pkg.sv */
// Constants, types and address map of the dual-port internal memory decoder
// Notes on behaviour
// - Addresses 0x0000_0000 to 0x0003_ffff go to the io_processor register region in every view.
// - Normal-word 0x0008_0000 to 0x0008_3fff selects block 0 SRAM.
// - Normal-word 0x000b_0000 to 0x000b_bfff selects block 0 ROM.
// - Normal-word 0x000c_0000 to 0x000c_3fff selects block 1 SRAM.
// - Normal-word 0x000f_0000 to 0x000f_bfff selects block 1 ROM.
// - Normal-word gaps between and after the blocks are reserved, backed by nothing.
// - Long-word 0x0004_0000 to 0x0004_1fff selects block 0 SRAM.
// - Long-word 0x0007_8000 to 0x0007_dfff is block 1 ROM; 0x0007_e000 up reserved.
// - Short-word 0x0016_0000 to 0x0017_7fff is block 0 ROM; 0x0010_8000 to 0x0015_ffff reserved.
// - Short-word 0x001e_0000 to 0x001f_7fff is block 1 ROM; 0x0018_8000 to 0x001d_ffff reserved.
// - Every block has two ports: one for the core, one for the io_processor.
// - Two core transfers not to the same SRAM block and one io_processor transfer complete in the same cycle.
// - Storage is reachable as 16, 32, 48 or 64-bit words, chosen by view and, in the normal view, by the wide48 request bit.
// - SRAM holds one megabit in total, shared by every word width.
// - Data and program buses hitting different blocks both complete in one cycle.
package dpmd_pkg;

   // ------------------------------------------------------------------
   // Widths and sizes
   // ------------------------------------------------------------------
   localparam int DATA_W = 64;
   localparam int LANE_W = 16;
   localparam int LANES = 4;
   localparam int SRAM_IDX_W = 15;
   localparam int ROM_IDX_W = 17;
   localparam int NUM_BLOCKS = 2;
   localparam int NUM_BUSES = 3;
   localparam int MAP_ENTRIES = 10;
   localparam logic [31:0] SRAM_SHORTS = 32'h0000_8000;
   localparam logic [31:0] ROM_SHORTS = 32'h0001_8000;
   localparam logic [31:0] IOREG_LAST = 32'h0003_ffff;
   // Mask content stand-in; the value is arbitrary
   localparam logic [15:0] ROM_PATTERN = 16'h5a3c;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      REGION_RESERVED = 2'b00,
      REGION_IOREG = 2'b01,
      REGION_SRAM = 2'b10,
      REGION_ROM = 2'b11
   } dpmd_region_type;

   typedef enum logic [1:0] {
      VIEW_LONG = 2'b00,
      VIEW_NORMAL = 2'b01,
      VIEW_SHORT = 2'b10
   } dpmd_view_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic wide48;
      logic [31:0] addr;
      logic [DATA_W-1:0] wdata;
   } dpmd_req_type;

   typedef struct packed {
      logic valid;
      dpmd_region_type region;
      logic [DATA_W-1:0] rdata;
   } dpmd_rsp_type;

   typedef struct packed {
      dpmd_region_type region;
      logic blk;
      logic [ROM_IDX_W-1:0] idx;
      logic [2:0] lanes;
   } dpmd_dec_type;

   typedef struct packed {
      logic [31:0] lo;
      logic [31:0] hi;
      dpmd_region_type region;
      logic blk;
      dpmd_view_type view;
   } dpmd_range_type;

   // ------------------------------------------------------------------
   // Address map; anything not listed above the register region is reserved
   // ------------------------------------------------------------------
   localparam dpmd_range_type MAP [MAP_ENTRIES] = '{
      '{32'h0004_0000, 32'h0004_1fff, REGION_SRAM, 1'b0, VIEW_LONG},
      '{32'h0007_8000, 32'h0007_dfff, REGION_ROM, 1'b1, VIEW_LONG},
      '{32'h0008_0000, 32'h0008_3fff, REGION_SRAM, 1'b0, VIEW_NORMAL},
      '{32'h000b_0000, 32'h000b_bfff, REGION_ROM, 1'b0, VIEW_NORMAL},
      '{32'h000c_0000, 32'h000c_3fff, REGION_SRAM, 1'b1, VIEW_NORMAL},
      '{32'h000f_0000, 32'h000f_bfff, REGION_ROM, 1'b1, VIEW_NORMAL},
      '{32'h0010_0000, 32'h0010_7fff, REGION_SRAM, 1'b0, VIEW_SHORT},
      '{32'h0016_0000, 32'h0017_7fff, REGION_ROM, 1'b0, VIEW_SHORT},
      '{32'h0018_0000, 32'h0018_7fff, REGION_SRAM, 1'b1, VIEW_SHORT},
      '{32'h001e_0000, 32'h001f_7fff, REGION_ROM, 1'b1, VIEW_SHORT}
   };

endpackage

/* File: verif/dpmd_core_model.sv */
// Core and io_processor request source facing the decoder
`timescale 1ns/1ps
module dpmd_core_model (
   input wire logic i_clock,
   input wire logic i_stall,
   output dpmd_pkg::dpmd_req_type o_dm,
   output dpmd_pkg::dpmd_req_type o_pm,
   output dpmd_pkg::dpmd_req_type o_io
);
   int refused = 0;
   // Requests stand until replaced; a refused one is only counted, never retried
   task automatic put(input dpmd_pkg::dpmd_req_type d, input dpmd_pkg::dpmd_req_type p,
                      input dpmd_pkg::dpmd_req_type i);
      o_dm = d;
      o_pm = p;
      o_io = i;
   endtask
   always @(posedge i_clock) begin
      if (o_pm.valid && i_stall) begin
         refused <= refused + 1;
      end
   end
endmodule

/* File: verif/dpmd_decoder_sva.sv */
// Port-level assertions for the dual-port memory decoder
`timescale 1ns/1ps
module dpmd_decoder_sva (
   input wire logic I_CLOCK,
   input wire logic I_SYS_RST,
   input wire dpmd_pkg::dpmd_req_type I_DATA_MEMORY_BUS_REQ,
   input wire dpmd_pkg::dpmd_req_type I_PROGRAM_MEMORY_BUS_REQ,
   input wire dpmd_pkg::dpmd_req_type I_IO_PROCESSOR_REQ,
   input wire logic O_PROGRAM_MEMORY_BUS_STALL,
   input wire dpmd_pkg::dpmd_rsp_type O_DATA_MEMORY_BUS_RSP,
   input wire dpmd_pkg::dpmd_rsp_type O_PROGRAM_MEMORY_BUS_RSP,
   input wire dpmd_pkg::dpmd_rsp_type O_IO_PROCESSOR_RSP
);
   wire dpmd_pkg::dpmd_req_type d = I_DATA_MEMORY_BUS_REQ;
   wire dpmd_pkg::dpmd_req_type p = I_PROGRAM_MEMORY_BUS_REQ;
   wire dpmd_pkg::dpmd_req_type i = I_IO_PROCESSOR_REQ;
   wire logic stl = O_PROGRAM_MEMORY_BUS_STALL;
   wire logic d_b0 = d.valid && d.addr >= 32'h0008_0000 && d.addr <= 32'h0008_3fff;
   wire logic p_b0 = p.valid && p.addr >= 32'h0008_0000 && p.addr <= 32'h0008_3fff;
   wire logic p_b1 = p.valid && p.addr >= 32'h000c_0000 && p.addr <= 32'h000c_3fff;
   wire logic d_rsv = d.valid && !d.write && d.addr >= 32'h0008_4000 && d.addr <= 32'h000a_ffff;
   wire logic i_rom = i.valid && i.addr >= 32'h000b_0000 && i.addr <= 32'h000b_bfff;

   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (I_SYS_RST);

   // ---------------------------------------------------------------
   // Request and answer steps
   // ---------------------------------------------------------------
   sequence d_taken;
      d.valid ##1 O_DATA_MEMORY_BUS_RSP.valid;
   endsequence
   sequence p_refused;
      p.valid && stl ##1 !O_PROGRAM_MEMORY_BUS_RSP.valid;
   endsequence

   dm_answer_a: assert property (d.valid |-> d_taken)
      else $error("data bus request not answered");
   dm_quiet_a: assert property (!d.valid |=> !O_DATA_MEMORY_BUS_RSP.valid)
      else $error("data bus answer without request");
   pm_answer_a: assert property (p.valid && !stl |=> O_PROGRAM_MEMORY_BUS_RSP.valid)
      else $error("program bus request not answered");
   pm_refuse_a: assert property (p.valid && stl |-> p_refused)
      else $error("refused program request answered");
   io_answer_a: assert property (i.valid |=> O_IO_PROCESSOR_RSP.valid)
      else $error("io request not answered");
   ioreg_map_a: assert property (d.valid && d.addr <= 32'h0003_ffff |=> O_DATA_MEMORY_BUS_RSP.region == dpmd_pkg::REGION_IOREG)
      else $error("register region not decoded");
   rsv_zero_a: assert property (d_rsv |=> O_DATA_MEMORY_BUS_RSP.region == dpmd_pkg::REGION_RESERVED && O_DATA_MEMORY_BUS_RSP.rdata == 64'h0)
      else $error("reserved read not empty");
   rom_map_a: assert property (i_rom |=> O_IO_PROCESSOR_RSP.region == dpmd_pkg::REGION_ROM)
      else $error("block 0 rom not decoded");
   same_block_a: assert property (d_b0 && p_b0 |-> stl)
      else $error("same block conflict not stalled");
   split_block_a: assert property (d_b0 && p_b1 |-> !stl)
      else $error("split blocks stalled");
endmodule

bind dpmd_decoder dpmd_decoder_sva u_dpmd_decoder_sva (
   .I_CLOCK(I_CLOCK),
   .I_SYS_RST(I_SYS_RST),
   .I_DATA_MEMORY_BUS_REQ(I_DATA_MEMORY_BUS_REQ),
   .I_PROGRAM_MEMORY_BUS_REQ(I_PROGRAM_MEMORY_BUS_REQ),
   .I_IO_PROCESSOR_REQ(I_IO_PROCESSOR_REQ),
   .O_PROGRAM_MEMORY_BUS_STALL(O_PROGRAM_MEMORY_BUS_STALL),
   .O_DATA_MEMORY_BUS_RSP(O_DATA_MEMORY_BUS_RSP),
   .O_PROGRAM_MEMORY_BUS_RSP(O_PROGRAM_MEMORY_BUS_RSP),
   .O_IO_PROCESSOR_RSP(O_IO_PROCESSOR_RSP)
);

/* File: verif/dual_port_internal_memory_decoder_test.sv */
// Self-checking bench with a lane-level reference model of both blocks
`timescale 1ns/1ps
module dual_port_internal_memory_decoder_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic stall;
   dpmd_pkg::dpmd_req_type dm, pm, io;
   dpmd_pkg::dpmd_rsp_type dmr, pmr, ior;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   int n_stall = 0;
   logic [31:0] lfsr = 32'h1f65;
   logic [15:0] mem [int];
   // Rows: first, last, region, block, shorts per word (0 means normal view)
   int mp [11][5] = '{'{0, 32'h3ffff, 1, 0, 0}, '{32'h40000, 32'h41fff, 2, 0, 4},
      '{32'h78000, 32'h7dfff, 3, 1, 4}, '{32'h80000, 32'h83fff, 2, 0, 0}, '{32'hb0000, 32'hbbfff, 3, 0, 0},
      '{32'hc0000, 32'hc3fff, 2, 1, 0}, '{32'hf0000, 32'hfbfff, 3, 1, 0}, '{32'h100000, 32'h107fff, 2, 0, 1},
      '{32'h160000, 32'h177fff, 3, 0, 1}, '{32'h180000, 32'h187fff, 2, 1, 1}, '{32'h1e0000, 32'h1f7fff, 3, 1, 1}};
   int rs [12] = '{32'h42000, 32'h7e000, 32'h84000, 32'haffff, 32'hbc000, 32'hc4000, 32'heffff, 32'hfc000,
      32'h108000, 32'h15ffff, 32'h188000, 32'h1dffff};
   int bs [7] = '{32'h40000, 32'h80000, 32'hc0000, 32'h100000, 32'h180000, 32'hb0000, 32'h84000};

   initial begin
      forever #2 clk = ~clk;
   end
   dpmd_core_model u_dpmd_core_model (.i_clock(clk), .i_stall(stall), .o_dm(dm), .o_pm(pm), .o_io(io));
   dpmd_decoder u_dpmd_decoder (.I_CLOCK(clk), .I_SYS_RST(rst), .I_DATA_MEMORY_BUS_REQ(dm),
      .I_PROGRAM_MEMORY_BUS_REQ(pm), .I_IO_PROCESSOR_REQ(io), .O_PROGRAM_MEMORY_BUS_STALL(stall),
      .O_DATA_MEMORY_BUS_RSP(dmr), .O_PROGRAM_MEMORY_BUS_RSP(pmr), .O_IO_PROCESSOR_RSP(ior));

   function automatic int dec(input logic [31:0] a, input logic w, output int b, output int x, output int n);
      dec = 0;
      b = 0;
      x = 0;
      n = 0;
      for (int k = 0; k < 11; k++) begin
         if (a >= mp[k][0] && a <= mp[k][1]) begin
            n = (mp[k][4] == 0) ? (w ? 3 : 2) : mp[k][4];
            b = mp[k][3];
            x = (a - mp[k][0]) * n;
            // A word running past the block end backs onto nothing
            dec = (k == 0 || x + n <= ((mp[k][2] == 2) ? 32'h8000 : 32'h18000)) ? mp[k][2] : 0;
         end
      end
   endfunction
   function automatic dpmd_pkg::dpmd_req_type rq(input logic w, input logic [31:0] a, input logic [63:0] wd,
                                                 input logic w48);
      return {1'b1, w, w48, a, wd};
   endfunction
   function automatic dpmd_pkg::dpmd_req_type rr();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      rr = rq(lfsr[0], 32'(bs[lfsr[3:1] % 7]) + 32'(lfsr[6:4]), {lfsr, ~lfsr}, lfsr[7]);
      rr.valid = lfsr[8];
   endfunction
   task automatic chk1(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk64(input logic [63:0] g, input logic [63:0] e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One cycle of requests on all three buses, answers checked one cycle on
   task automatic cyc(input dpmd_pkg::dpmd_req_type d, input dpmd_pkg::dpmd_req_type p,
                      input dpmd_pkg::dpmd_req_type i);
      dpmd_pkg::dpmd_req_type q [3];
      dpmd_pkg::dpmd_rsp_type g [3];
      logic [63:0] e [3], m [3];
      logic [15:0] tw [int];
      int r [3], b [3], x [3], n [3];
      int key;
      logic es, st;
      q = '{d, p, i};
      u_dpmd_core_model.put(d, p, i);
      #1;
      st = stall;
      for (int k = 0; k < 3; k++) begin
         r[k] = dec(q[k].addr, q[k].wide48, b[k], x[k], n[k]);
      end
      es = d.valid && p.valid && r[0] == 2 && r[1] == 2 && b[0] == b[1];
      q[1].valid = q[1].valid && !es;
      n_stall = n_stall + int'(es);
      // Core writes land last so they win a same-location collision
      for (int k = 2; k >= 0; k--) begin
         for (int l = 0; l < n[k]; l++) begin
            if (q[k].valid && q[k].write && r[k] == 2) begin
               tw[b[k] * 262144 + x[k] + l] = q[k].wdata[16 * l +: 16];
            end
         end
      end
      for (int k = 0; k < 3; k++) begin
         e[k] = '0;
         m[k] = (r[k] >= 2) ? '0 : '1;
         for (int l = 0; l < n[k]; l++) begin
            key = b[k] * 262144 + x[k] + l;
            // ROM writes are dropped but still answer with the old mask content
            if (r[k] == 3) begin
               m[k][16 * l +: 16] = 16'hffff;
               e[k][16 * l +: 16] = {b[k][0], 15'(x[k] + l)} ^ 16'h5a3c;
            end else if (!q[k].write && r[k] == 2 && mem.exists(key) && !tw.exists(key)) begin
               m[k][16 * l +: 16] = 16'hffff;
               e[k][16 * l +: 16] = mem[key];
            end
         end
      end
      foreach (tw[j]) begin
         mem[j] = tw[j];
      end
      @(posedge clk);
      #1;
      g = '{dmr, pmr, ior};
      chk1(st, es);
      for (int k = 0; k < 3; k++) begin
         chk1(g[k].valid, q[k].valid);
         if (q[k].valid) begin
            chk64(64'(g[k].region), 64'(r[k]));
            chk64(g[k].rdata & m[k], e[k]);
         end
      end
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         end_of_test();
      end
   end

   initial begin
      u_dpmd_core_model.put('0, '0, '0);
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      for (int k = 0; k < 11; k++) begin
         cyc('0, '0, rq(0, 32'(mp[k][0]), 0, 0));
         cyc('0, '0, rq(0, 32'(mp[k][1]), 0, 0));
      end
      for (int k = 0; k < 12; k++) begin
         cyc(rq(0, 32'(rs[k]), 0, 0), '0, '0);
      end
      for (int k = 0; k < 8; k++) begin
         cyc('0, '0, rq(1, 32'h0010_0000 + 32'(k), 64'(rr()), 0));
      end
      cyc(rq(0, 32'h0004_0000, 0, 0), rq(0, 32'h000c_0000, 0, 0), rq(0, 32'h0008_0001, 0, 1));
      cyc('0, rq(1, 32'h000c_0002, 64'h1234_5678, 0), '0);
      cyc(rq(0, 32'h0008_0002, 0, 0), '0, rq(0, 32'h0018_0004, 0, 0));
      cyc(rq(0, 32'h0010_0001, 0, 0), rq(0, 32'h000c_0002, 0, 0), rq(1, 32'h0010_0006, 64'hab, 0));
      cyc(rq(0, 32'h0008_0000, 0, 0), rq(0, 32'h0004_0001, 0, 0), '0);
      cyc('0, rq(0, 32'h0004_0001, 0, 0), '0);
      cyc(rq(0, 32'h0008_2aa9, 0, 1), '0, rq(0, 32'h0008_2aaa, 0, 1));
      cyc('0, '0, rq(1, 32'h0016_0000, 64'hffff, 0));
      cyc(rq(0, 32'h0016_0000, 0, 0), '0, '0);
      u_dpmd_core_model.put('0, '0, '0);
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk1(dmr.valid, 1'b0);
      rst = 1'b0;
      repeat (300) begin
         cyc(rr(), rr(), rr());
      end
      chk64(64'(u_dpmd_core_model.refused), 64'(n_stall));
      end_of_test();
   end
endmodule
